// File: rtl/led_pkg.sv
// Purpose: shared constants, types and pin carrier for the led sink core
// Assumes: 250 MHz core clock; all pins arrive asynchronous to it
// Notes:   sequence codes are counts of shift clock rises inside one strobe
//
// Operation
// - adjacent outputs switch about 20 ns apart
// - enable waveform gates every latched-on output
// - short-detect entry sequence; its strobe never latches
// - open-detect entry sequence; its strobe never latches
// - normal-return sequence leaves either detection mode
// - error code readable serially after read sequence
// - open-detect bit: 0 open, 1 normal
// - short-detect bit: 0 short, 1 normal
// - enable falling starts detection while outputs sink
// - status loads on third clock rise after fall
// - serial input ignored while enable low detecting
// - enable rise: status shifts out per clock
package led_pkg;

    // channel count and core clock
    localparam int OUT_COUNT     = 16;
    localparam int CLK_PERIOD_PS = 4000;

    // output stagger, least time rounded up to whole cycles
    localparam int STAGGER_NS    = 20;
    localparam int STAGGER_CYC   = (STAGGER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TMR_W         = 3;

    // controller-side wait before the capturing clock
    localparam int DETECT_WAIT_NS  = 2000;
    localparam int DETECT_WAIT_CYC =
        (DETECT_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // buffering between shift stage and output latch
    localparam int FIFO_DEPTH    = 4;

    // sequence codes: shift clock rises seen during one strobe pulse
    localparam logic [1:0] SEQ_LATCH  = 2'h0;
    localparam logic [1:0] SEQ_OPEN   = 2'h1;
    localparam logic [1:0] SEQ_SHORT  = 2'h2;
    localparam logic [1:0] SEQ_NORMAL = 2'h3;

    // capture counter: index of capturing rise, and idle value
    localparam logic [1:0] CAP_EDGE   = 2'h2;
    localparam logic [1:0] CAP_IDLE   = 2'h3;

    // operating modes
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_OPEN,
        MODE_SHORT
    } mode_t;

    // control pins from the controller
    typedef struct packed {
        logic sck;       // shift clock
        logic serial_in;       // serial_in
        logic strobe;    // latch_strobe, active high
        logic enable_n;  // output enable, active low
    } pin_in_t;

    localparam pin_in_t PINS_RST = '{sck: 1'b0, serial_in: 1'b0, strobe: 1'b0, enable_n: 1'b1};

endpackage : led_pkg

// File: rtl/stream_fifo.sv
// Purpose: small valid/ready fifo between shift stage and output latch
// Assumes: single clock, asynchronous active-low reset
// Notes:   DEPTH need not be a power of two
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];  // storage
    logic [AW-1:0]    wr_q;         // write pointer
    logic [AW-1:0]    rd_q;         // read pointer
    logic [AW:0]      cnt_q;        // fill level
    logic             push;
    logic             pop;

    // honest full and empty from the fill level
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage write, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // pointers and level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule : stream_fifo

// File: rtl/led_sink_core.sv
// Purpose: control logic of a 16-channel sink driver with open/short detect
// Assumes: pins and sense inputs asynchronous; sampled by clk through two flops
// Notes:   strobe with 0 clock rises latches in normal mode; 1 open, 2 short, 3 normal
`timescale 1ns/1ps
module led_sink_core #(
    parameter int NUM_OUT    = led_pkg::OUT_COUNT,
    parameter int FIFO_DEPTH = led_pkg::FIFO_DEPTH
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire led_pkg::pin_in_t   pins,
    input  wire logic [NUM_OUT-1:0] open_sense_ok,
    input  wire logic [NUM_OUT-1:0] short_sense_ok,
    output logic [NUM_OUT-1:0]      sink_on,
    output logic                    serial_out,
    output logic                    open_detect_mode,
    output logic                    short_detect_mode,
    output logic                    latch_overrun
);
    import led_pkg::*;

    localparam int IDX_W = $clog2(NUM_OUT) + 1;

    // synchronisers and edge history
    pin_in_t            sync1_q;     // first stage, read only by sync2_q
    pin_in_t            sync2_q;     // settled pins
    pin_in_t            prev_q;      // previous settled pins
    logic [NUM_OUT-1:0] open_s1_q;
    logic [NUM_OUT-1:0] open_s2_q;
    logic [NUM_OUT-1:0] short_s1_q;
    logic [NUM_OUT-1:0] short_s2_q;

    // decoded edges
    logic sck_rise;
    logic strobe_rise;
    logic strobe_fall;
    logic en_fall;
    logic en_on;

    // control state
    mode_t              mode_q;      // operating mode
    logic [1:0]         edges_q;     // clock rises inside current strobe
    logic [1:0]         cap_cnt_q;   // clock rises since enable fell
    logic               capture;
    logic               shift_ok;
    logic [NUM_OUT-1:0] shreg_q;     // shift register
    logic               pend_q;      // latch word waiting for fifo
    logic [NUM_OUT-1:0] word_q;      // word waiting for fifo
    logic               latch_set;
    logic               open_q;
    logic               short_q;
    logic               overrun_q;

    // fifo wires
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic [NUM_OUT-1:0] fifo_out_data;

    // output stage
    logic [NUM_OUT-1:0] latch_q;     // output latch
    logic [NUM_OUT-1:0] desired;     // latch gated by enable
    logic [NUM_OUT-1:0] sink_q;      // staggered sink drive
    logic [NUM_OUT-1:0] target_q;    // sweep snapshot
    logic [IDX_W-1:0]   idx_q;       // sweep position
    logic [TMR_W-1:0]   tmr_q;       // spacing timer
    logic               busy_q;      // sweep running
    logic               sweep_start;

    assign sink_on           = sink_q;
    assign serial_out        = shreg_q[NUM_OUT-1];
    assign open_detect_mode  = open_q;
    assign short_detect_mode = short_q;
    assign latch_overrun     = overrun_q;

    // two-flop synchronisers for every outside input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q    <= PINS_RST;
            sync2_q    <= PINS_RST;
            prev_q     <= PINS_RST;
            open_s1_q  <= '1;
            open_s2_q  <= '1;
            short_s1_q <= '1;
            short_s2_q <= '1;
        end else begin
            sync1_q    <= pins;
            sync2_q    <= sync1_q;
            prev_q     <= sync2_q;
            open_s1_q  <= open_sense_ok;
            open_s2_q  <= open_s1_q;
            short_s1_q <= short_sense_ok;
            short_s2_q <= short_s1_q;
        end
    end

    // edge finding on settled pins only
    assign sck_rise    = sync2_q.sck & ~prev_q.sck;
    assign strobe_rise = sync2_q.strobe & ~prev_q.strobe;
    assign strobe_fall = ~sync2_q.strobe & prev_q.strobe;
    assign en_fall     = ~sync2_q.enable_n & prev_q.enable_n;
    assign en_on       = ~sync2_q.enable_n;

    // count clock rises inside a strobe pulse to decode the sequence
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edges_q <= SEQ_LATCH;
        end else if (strobe_rise) begin
            edges_q <= SEQ_LATCH;
        end else if (sck_rise && sync2_q.strobe && edges_q != SEQ_NORMAL) begin
            edges_q <= edges_q + 2'h1;
        end
    end

    // mode changes at strobe fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_NORMAL;
        end else if (strobe_fall) begin
            unique case (edges_q)
                SEQ_LATCH:  mode_q <= mode_q;       // plain latch pulse
                SEQ_OPEN:   mode_q <= MODE_OPEN;
                SEQ_SHORT:  mode_q <= MODE_SHORT;
                SEQ_NORMAL: mode_q <= MODE_NORMAL;
            endcase
        end
    end

    // registered mode flags for the analog comparators
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            open_q  <= 1'b0;
            short_q <= 1'b0;
        end else begin
            open_q  <= (mode_q == MODE_OPEN);
            short_q <= (mode_q == MODE_SHORT);
        end
    end

    // clock rises since enable fell, detection modes only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt_q <= CAP_IDLE;
        end else if (en_fall && mode_q != MODE_NORMAL) begin
            cap_cnt_q <= 2'h0;
        end else if (sck_rise && en_on && mode_q != MODE_NORMAL && cap_cnt_q != CAP_IDLE) begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
        end
    end

    // third rise after the fall loads the status
    assign capture  = sck_rise & en_on & ~en_fall & (mode_q != MODE_NORMAL)
                    & (cap_cnt_q == CAP_EDGE);
    // serial input closed while enable low in a detection mode
    assign shift_ok = (mode_q == MODE_NORMAL) | ~en_on;

    // shift register: status load or serial shift
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg_q <= '0;
        end else if (capture) begin
            shreg_q <= (mode_q == MODE_OPEN) ? open_s2_q
                                             : short_s2_q;
        end else if (sck_rise && shift_ok) begin
            shreg_q <= {shreg_q[NUM_OUT-2:0], sync2_q.serial_in};
        end
    end

    // latch request only for a strobe without clock rises in normal mode
    assign latch_set = strobe_fall & (edges_q == SEQ_LATCH) & (mode_q == MODE_NORMAL);

    // hold the word until the fifo takes it; a new set wins over the take
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q    <= 1'b0;
            word_q    <= '0;
            overrun_q <= 1'b0;
        end else begin
            if (latch_set) begin
                pend_q <= 1'b1;
                word_q <= shreg_q;
            end else if (fifo_in_ready) begin
                pend_q <= 1'b0;
            end
            // flag a word replaced before the fifo could take it
            overrun_q <= latch_set & pend_q & ~fifo_in_ready;
        end
    end

    stream_fifo #(
        .WIDTH (NUM_OUT),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (pend_q),
        .in_ready  (fifo_in_ready),
        .in_data   (word_q),
        .out_valid (fifo_out_valid),
        .out_ready (~busy_q),
        .out_data  (fifo_out_data)
    );

    // output latch loads from the fifo between sweeps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= '0;
        end else if (fifo_out_valid && !busy_q) begin
            latch_q <= fifo_out_data;
        end
    end

    // enable gates every latched-on output
    assign desired     = latch_q & {NUM_OUT{en_on}};
    assign sweep_start = ~busy_q & (desired != sink_q);

    // staggered sweep: one output per spacing interval
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q   <= 1'b0;
            idx_q    <= '0;
            tmr_q    <= '0;
            target_q <= '0;
            sink_q   <= '0;
        end else if (sweep_start) begin
            busy_q   <= 1'b1;
            idx_q    <= '0;
            tmr_q    <= '0;
            target_q <= desired;
        end else if (busy_q) begin
            if (tmr_q != '0) begin
                tmr_q <= tmr_q - 1'b1;
            end else if (idx_q == IDX_W'(NUM_OUT)) begin
                busy_q <= 1'b0;  // last gap has run out
            end else begin
                sink_q[idx_q[IDX_W-2:0]] <= target_q[idx_q[IDX_W-2:0]];
                idx_q <= idx_q + 1'b1;
                tmr_q <= TMR_W'(STAGGER_CYC - 1);
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_stagger;
        $changed(sink_q) |=> !$changed(sink_q) [*4];
    endproperty
    a_stagger: assert property (p_stagger) else $error("outputs switched too close");

    property p_one_bit;
        $countones(sink_q ^ $past(sink_q)) <= 1;
    endproperty
    a_one_bit: assert property (p_one_bit) else $error("two outputs switched at once");

    // a finished sweep must leave every output at the gated snapshot
    property p_gate;
        $fell(busy_q) |-> sink_q == target_q;
    endproperty
    a_gate: assert property (p_gate) else $error("sweep left outputs off target");

    property p_short_entry;
        strobe_fall && edges_q == SEQ_SHORT |=> mode_q == MODE_SHORT && $stable(pend_q);
    endproperty
    a_short_entry: assert property (p_short_entry) else $error("short entry failed");

    property p_open_entry;
        strobe_fall && edges_q == SEQ_OPEN |=> mode_q == MODE_OPEN && $stable(word_q);
    endproperty
    a_open_entry: assert property (p_open_entry) else $error("open entry failed");

    property p_normal;
        strobe_fall && edges_q == SEQ_NORMAL |=> ##1 !open_q && !short_q;
    endproperty
    a_normal: assert property (p_normal) else $error("normal return failed");

    property p_open_code;
        capture && mode_q == MODE_OPEN |=> shreg_q == $past(open_s2_q);
    endproperty
    a_open_code: assert property (p_open_code) else $error("open status wrong");

    property p_short_code;
        capture && mode_q == MODE_SHORT |=> shreg_q == $past(short_s2_q);
    endproperty
    a_short_code: assert property (p_short_code) else $error("short status wrong");

    // one capture per enable fall: the counter parks after the third rise
    property p_third;
        capture |=> cap_cnt_q == CAP_IDLE && !capture;
    endproperty
    a_third: assert property (p_third) else $error("capture not on third rise");

    property p_hold_sin;
        sck_rise && en_on && mode_q != MODE_NORMAL && !capture |=> $stable(shreg_q);
    endproperty
    a_hold_sin: assert property (p_hold_sin) else $error("shifted while detecting");

    property p_shift;
        sck_rise && shift_ok && !capture
            |=> shreg_q == {$past(shreg_q[NUM_OUT-2:0]), $past(sync2_q.serial_in)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift wrong");

    // with an empty path and no sweep, a latched word reaches the latch promptly
    property p_latch_cycle;
        latch_set && !pend_q && !fifo_out_valid && !busy_q && !sweep_start
            |=> ##[1:3] latch_q == word_q;
    endproperty
    a_latch_cycle: assert property (p_latch_cycle) else $error("latch word lost");

    c_open:    cover property (strobe_fall && edges_q == SEQ_OPEN);
    c_capture: cover property (capture);
    c_full:    cover property (pend_q && !fifo_in_ready);
    c_sweep:   cover property (busy_q && idx_q == IDX_W'(NUM_OUT));

endmodule : led_sink_core

// File: verif/led_ctrl_model.sv
// Purpose: controller model driving the shift, strobe and enable pins
// Assumes: 80 ns shift clock period, i.e. 20 core clocks
// Notes:   pins change only just after a rising core clock edge
`timescale 1ns/1ps
module led_ctrl_model
    import led_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       serial_out,
    output led_pkg::pin_in_t pins
);
    // idle pin levels until the bench calls a task
    initial begin
        pins = PINS_RST;
    end

    // wait whole core clocks
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // one shift clock period, data set up during the low half
    task automatic sck_pulse(input logic b);
        @(posedge clk);
        pins.serial_in <= b;
        idle(9);
        pins.sck <= 1'b1;
        idle(10);
        pins.sck <= 1'b0;
    endtask : sck_pulse

    // sixteen bits, bit15 first so it lands in the last stage
    task automatic shift_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            sck_pulse(w[i]);
        end
    endtask : shift_word

    // strobe with n shift clock rises inside: 0 latch, 1 open, 2 short, 3 normal
    task automatic seq(input int n);
        @(posedge clk);
        pins.strobe <= 1'b1;
        idle(10);
        for (int i = 0; i < n; i++) begin
            sck_pulse(1'b0);
        end
        idle(10);
        pins.strobe <= 1'b0;
        idle(10);
    endtask : seq

    // enable level, held long enough for a sweep to start
    task automatic set_en(input logic v);
        @(posedge clk);
        pins.enable_n <= v;
        idle(10);
    endtask : set_en

    // enable fall, three clocks, third after the detect wait, enable rise
    task automatic detect;
        set_en(1'b0);
        sck_pulse(1'b1);
        sck_pulse(1'b0);
        idle(DETECT_WAIT_CYC);
        sck_pulse(1'b1); // serial input toggled while it must be ignored
        set_en(1'b1);
    endtask : detect

    // collect the status word, msb first, one bit per shift clock
    task automatic read_word(output logic [15:0] w);
        w = '0;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            w = {w[14:0], serial_out};
            if (i < 15) begin
                sck_pulse(1'b0);
            end
        end
    endtask : read_word
endmodule : led_ctrl_model

// File: verif/led_sink_driver_fault_detect_tb.sv
// Purpose: self-checking bench for the led sink core
// Assumes: 250 MHz core clock, controller model on the pins
// Notes:   driver queues notes, monitor compares them as results appear
`timescale 1ns/1ps
module led_sink_driver_fault_detect_tb;
    import led_pkg::*;

    typedef struct packed {
        logic [2:0]  sel;  // which result is looked at
        logic [15:0] val;  // expected value
    } note_t;

    logic        clk;         // core clock
    logic        rst_n;       // async reset
    pin_in_t     pins;        // controller pins
    logic [15:0] open_ok;     // open comparators
    logic [15:0] short_ok;    // short comparators
    logic [15:0] sink_on;     // sink drive
    logic        serial_out;  // serial output
    logic        open_mode;   // open-detect flag
    logic        short_mode;  // short-detect flag
    logic        overrun;     // latch overrun pulse
    logic [31:0] lfsr_q;      // random source
    note_t       exp_q[$];    // pending expectations
    logic [15:0] obs;         // value collected by the driver
    logic        look;        // monitor strobe
    logic        ovr_seen;    // overrun pulse noticed
    int          n_errors;
    int          cmp_count;
    int          cyc;
    int          t0;
    int          t1;
    logic [15:0] w;
    logic [15:0] rd;

    led_sink_core led_sink_core_inst (
        .clk               (clk),
        .rst_n             (rst_n),
        .pins              (pins),
        .open_sense_ok     (open_ok),
        .short_sense_ok    (short_ok),
        .sink_on           (sink_on),
        .serial_out        (serial_out),
        .open_detect_mode  (open_mode),
        .short_detect_mode (short_mode),
        .latch_overrun     (overrun)
    );

    led_ctrl_model led_ctrl_model_inst (
        .clk        (clk),
        .serial_out (serial_out),
        .pins       (pins)
    );

    // clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // next random word from the lfsr
    function automatic logic [15:0] rnd16();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q[15:0] ^ lfsr_q[31:16];
    endfunction : rnd16

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // verdict and end of run
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // queue a note and strobe the monitor one cycle later
    task automatic note(input logic [2:0] sel, input logic [15:0] val, input logic [15:0] seen);
        exp_q.push_back('{sel: sel, val: val});
        @(posedge clk);
        obs  <= seen;
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask : note

    // stagger timestamps and overrun pulse
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (sink_on[0] === 1'b1 && t0 == 0) t0 <= cyc;
        if (sink_on[1] === 1'b1 && t1 == 0) t1 <= cyc;
        if (overrun === 1'b1) ovr_seen <= 1'b1;
    end

    // monitor: oldest note against the outputs
    always @(posedge clk) begin
        note_t n;
        if (look) begin
            n = exp_q.pop_front();
            case (n.sel)
                3'h0: check(sink_on, n.val);
                3'h1: check(obs, n.val);
                3'h2: check(obs, n.val);
                3'h3: check({14'h0, short_mode, open_mode}, n.val);
                3'h4: check(16'(t1 - t0), n.val);
                3'h5: check({15'h0, ovr_seen}, n.val);
                default: check({15'h0, serial_out}, n.val);
            endcase
        end
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        lfsr_q = 32'hc176;
        rst_n = 1'b0;
        look = 1'b0;
        obs = 16'h0;
        ovr_seen = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        cyc = 0;
        t0 = 0;
        t1 = 0;
        open_ok = rnd16();
        short_ok = rnd16();
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // normal shift, latch and staggered turn-on
        w = rnd16();
        w = w | 16'h0003;
        led_ctrl_model_inst.set_en(1'b0);
        led_ctrl_model_inst.shift_word(w);
        note(3'h6, {15'h0, w[15]}, 16'h0);
        led_ctrl_model_inst.seq(0);
        led_ctrl_model_inst.idle(120);
        note(3'h0, w, 16'h0);
        note(3'h4, 16'(STAGGER_CYC), 16'h0);
        $display("test latch done");
        // enable waveform gates the outputs
        led_ctrl_model_inst.set_en(1'b1);
        led_ctrl_model_inst.idle(120);
        note(3'h0, 16'h0, 16'h0);
        led_ctrl_model_inst.set_en(1'b0);
        led_ctrl_model_inst.idle(120);
        note(3'h0, w, 16'h0);
        $display("test gating done");
        // open and short detect, read, strobe left the latch alone
        for (int m = 1; m <= 2; m++) begin
            rd = rnd16();
            @(posedge clk);
            if (m == 1) open_ok <= rd;
            else short_ok <= rd;
            led_ctrl_model_inst.set_en(1'b1);
            led_ctrl_model_inst.seq(m);
            note(3'h3, 16'(m), 16'h0);
            led_ctrl_model_inst.detect();
            led_ctrl_model_inst.read_word(obs);
            note(3'(m), rd, obs);
            led_ctrl_model_inst.set_en(1'b0);
            led_ctrl_model_inst.idle(120);
            note(3'h0, w, 16'h0);
            led_ctrl_model_inst.set_en(1'b1);
            led_ctrl_model_inst.seq(3);
            note(3'h3, 16'h0, 16'h0);
            $display("test detect mode %0d done", m);
        end
        // burst of latches, each word one shift apart, overruns the buffer
        w = rnd16();
        led_ctrl_model_inst.shift_word(w);
        led_ctrl_model_inst.set_en(1'b0);
        for (int i = 0; i < 28; i++) begin
            rd = rnd16();
            led_ctrl_model_inst.sck_pulse(rd[0]);
            w = {w[14:0], rd[0]};
            led_ctrl_model_inst.seq(0);
        end
        for (int i = 0; i < 1000 && !ovr_seen; i++) begin
            @(posedge clk);
        end
        note(3'h5, 16'h1, 16'h0);
        led_ctrl_model_inst.idle(1000);
        note(3'h0, w, 16'h0);
        $display("test overrun done");
        repeat (3) @(posedge clk);
        tally_and_finish();
    end
endmodule : led_sink_driver_fault_detect_tb
